// *** hdl/gtc_counter.sv ***
// gtc_counter: four-channel gated event counter with register port
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module gtc_counter #(
    parameter int NUM_CH          = gtc_pkg::NUM_CHANNELS,
    parameter int CW              = gtc_pkg::COUNT_WIDTH,
    parameter int ACTIVITY_CYCLES = gtc_pkg::ACTIVITY_CYCLES
) (
    input  wire logic                            core_clk,
    input  wire logic                            rst,
    input  wire logic [gtc_pkg::ADDR_WIDTH-1:0]  regAddr,
    input  wire logic [gtc_pkg::DATA_WIDTH-1:0]  regWrData,
    input  wire logic                            regWrite,
    input  wire logic                            regRead,
    output logic      [gtc_pkg::DATA_WIDTH-1:0]  regRdData,
    input  wire logic [NUM_CH-1:0]               pulseInput,
    input  wire logic [NUM_CH-1:0]               gateInput,
    output logic      [NUM_CH-1:0]               compareToggleOutput,
    input  wire logic                            hostAttached,
    input  wire logic                            transferActive,
    output logic                                 statusLamp,
    output logic                                 activityLamp
);
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    logic       inWindow;
    logic [1:0] chSel;
    logic [4:0] ofs;
    assign inWindow = (regAddr < gtc_pkg::ADR_SCAN_MASK);
    assign chSel    = regAddr[6:5];
    assign ofs      = regAddr[4:0];

    logic scanCmdWr;
    assign scanCmdWr = regWrite && regAddr == gtc_pkg::ADR_SCAN_CMD;

    logic [NUM_CH-1:0] scanMask;
    logic [NUM_CH-1:0] halted;
    logic [CW-1:0]     reloadValue;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            scanMask <= '0;
        else if (regWrite && regAddr == gtc_pkg::ADR_SCAN_MASK)
            scanMask <= regWrData[NUM_CH-1:0];
    end

    // reload value is shared: one 64-bit staging register, low word then high word
    always_ff @(posedge core_clk)
    begin
        if (rst)
            reloadValue <= '0;
        else if (regWrite && regAddr == gtc_pkg::ADR_RELOAD)
            reloadValue <= {reloadValue[CW-1:32], regWrData};
        else if (regWrite && regAddr == gtc_pkg::ADR_RELOAD + 8'h04)
            reloadValue <= {regWrData, reloadValue[31:0]};
    end

    // ----------------------------------------
    // per-channel logic
    // ----------------------------------------
    logic [CW-1:0]                   countQ    [NUM_CH];
    logic [CW-1:0]                   minLim    [NUM_CH];
    logic [CW-1:0]                   maxLim    [NUM_CH];
    logic [CW-1:0]                   readLatch [NUM_CH];
    logic [gtc_pkg::CFG_WIDTH-1:0]   cfg       [NUM_CH];
    logic [31:0]                     cmpReg    [NUM_CH];

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            logic [2:0] pulseSync;
            logic [2:0] gateSync;
            logic       pulseEdge;
            logic       gateLevel;
            logic       gatePrev;
            logic       gateRise;
            logic       chWr;
            logic       readLo;
            logic       scanHit;
            logic       clrRead;
            logic       reloadHit;
            logic       accum;
            gtc_pkg::gtc_gate_e gateFn;
            logic       rangeOn;
            logic       downDir;
            logic       enabled;
            logic       started;
            logic       gateClear;
            logic [CW-1:0] floorVal;
            logic [CW-1:0] next_count;
            logic       dirPrev;

            assign chWr   = regWrite && inWindow && chSel == 2'(ch);
            // the low word read is the read that latches a 64-bit snapshot
            assign readLo = regRead && inWindow && chSel == 2'(ch) && ofs == gtc_pkg::OFS_COUNT_LO;
            assign scanHit = scanCmdWr && scanMask[ch];
            assign clrRead = (readLo || scanHit) && cfg[ch][gtc_pkg::CFG_CLR_ON_READ];
            assign reloadHit = regWrite && regAddr == gtc_pkg::ADR_STATUS && regWrData[ch];

            // first stage only feeds the second; edges are taken from stages two and three
            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    pulseSync <= '0;
                    gateSync  <= '0;
                end
                else
                begin
                    pulseSync <= {pulseSync[1:0], pulseInput[ch]};
                    gateSync  <= {gateSync[1:0], gateInput[ch]};
                end
            end
            assign pulseEdge = pulseSync[1] && !pulseSync[2];
            assign gateLevel = gateSync[1] ^ cfg[ch][gtc_pkg::CFG_GATE_INVERT];
            assign gatePrev  = gateSync[2] ^ cfg[ch][gtc_pkg::CFG_GATE_INVERT];
            assign gateRise  = gateLevel && !gatePrev;

            assign accum   = cfg[ch][gtc_pkg::CFG_MODE_LSB +: 2] == gtc_pkg::MODE_ACCUMULATE;
            // gate options exist only in accumulate mode
            assign gateFn  = accum ? gtc_pkg::gtc_gate_e'(cfg[ch][gtc_pkg::CFG_GATE_LSB +: 3])
                                   : gtc_pkg::GATE_NONE;
            assign rangeOn = cfg[ch][gtc_pkg::CFG_RANGE_LIMIT];
            assign floorVal = rangeOn ? minLim[ch] : '0;
            assign downDir = (gateFn == gtc_pkg::GATE_DIRECTION) ? !gateLevel
                                                                 : cfg[ch][gtc_pkg::CFG_REVERSE];
            assign enabled = accum && started && !halted[ch]
                             && (gateFn != gtc_pkg::GATE_ENABLE || gateLevel);
            assign gateClear = gateFn == gtc_pkg::GATE_CLEAR_RELOAD && gateRise;

            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    cfg[ch]    <= gtc_pkg::CFG_RESET;
                    minLim[ch] <= '0;
                    maxLim[ch] <= '1;
                    cmpReg[ch] <= '0;
                end
                else if (chWr)
                begin
                    // limit writes set the limit registers and return the compare output to its initial level, never touch the count
                    case (ofs)
                        gtc_pkg::OFS_CONFIG:   cfg[ch]    <= regWrData[gtc_pkg::CFG_WIDTH-1:0];
                        gtc_pkg::OFS_MIN_LO:   minLim[ch] <= {minLim[ch][CW-1:32], regWrData};
                        gtc_pkg::OFS_MIN_HI:   minLim[ch] <= {regWrData, minLim[ch][31:0]};
                        gtc_pkg::OFS_MAX_LO:   maxLim[ch] <= {maxLim[ch][CW-1:32], regWrData};
                        gtc_pkg::OFS_MAX_HI:   maxLim[ch] <= {regWrData, maxLim[ch][31:0]};
                        gtc_pkg::OFS_CMP:      cmpReg[ch] <= regWrData;
                        default:               cfg[ch]    <= cfg[ch];
                    endcase
                end
            end

            // trigger gating: wait for the active edge before the first count
            // a config write re-arms first, since the old gate function is still in force at that edge;
            // the cost is one cycle without counting after any config write
            always_ff @(posedge core_clk)
            begin
                if (rst)
                    started <= 1'b0;
                else if (chWr && ofs == gtc_pkg::OFS_CONFIG)
                    started <= 1'b0;
                else if (gateFn != gtc_pkg::GATE_TRIGGER)
                    started <= 1'b1;
                else if (gateRise)
                    started <= 1'b1;
            end

            always_comb
            begin
                next_count = countQ[ch];
                if (enabled && pulseEdge)
                begin
                    if (!downDir)
                    begin
                        if (rangeOn && countQ[ch] >= maxLim[ch])
                            next_count = cfg[ch][gtc_pkg::CFG_ROLL_FREEZE] ? maxLim[ch] : minLim[ch];
                        else
                            next_count = countQ[ch] + 1'b1;
                    end
                    else
                    begin
                        if (rangeOn && countQ[ch] <= minLim[ch])
                            next_count = cfg[ch][gtc_pkg::CFG_ROLL_FREEZE] ? minLim[ch] : maxLim[ch];
                        else
                            next_count = countQ[ch] - 1'b1;
                    end
                end
            end

            // a read-clear or gate clear beats a coinciding pulse; the pulse is lost by design
            always_ff @(posedge core_clk)
            begin
                if (rst)
                    countQ[ch] <= '0;
                else if (reloadHit)
                    countQ[ch] <= reloadValue;
                else if (clrRead || gateClear)
                    countQ[ch] <= floorVal;
                else
                    countQ[ch] <= next_count;
            end

            always_ff @(posedge core_clk)
            begin
                if (rst)
                    readLatch[ch] <= '0;
                else if (readLo || scanHit)
                    readLatch[ch] <= countQ[ch];
            end

            // non-recycle freeze at the limits
            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    halted[ch] <= 1'b0;
                    dirPrev    <= 1'b0;
                end
                else
                begin
                    dirPrev <= downDir;
                    if (!cfg[ch][gtc_pkg::CFG_NON_RECYCLE])
                        halted[ch] <= 1'b0;
                    else if (reloadHit)
                        halted[ch] <= !(reloadValue > minLim[ch] && reloadValue < maxLim[ch]);
                    else if (dirPrev != downDir)
                        halted[ch] <= 1'b0;
                    else if (!halted[ch] && enabled && pulseEdge)
                        halted[ch] <= downDir ? (next_count == minLim[ch])
                                              : (next_count == maxLim[ch]);
                end
            end

            always_ff @(posedge core_clk)
            begin
                if (rst)
                    compareToggleOutput[ch] <= 1'b0;
                else if (!cfg[ch][gtc_pkg::CFG_OUTPUT_ON] || chWr)
                    compareToggleOutput[ch] <= cfg[ch][gtc_pkg::CFG_OUTPUT_INIT];
                else if (countQ[ch][15:0] == cmpReg[ch][gtc_pkg::CMP_HALF +: 16])
                    compareToggleOutput[ch] <= cfg[ch][gtc_pkg::CFG_OUTPUT_INIT];
                else if (countQ[ch][15:0] == cmpReg[ch][15:0])
                    compareToggleOutput[ch] <= !cfg[ch][gtc_pkg::CFG_OUTPUT_INIT];
            end
        end
    endgenerate

    // ----------------------------------------
    // read data, one cycle after the strobe
    // ----------------------------------------
    logic [31:0] next_rdData;
    always_comb
    begin
        next_rdData = '0;
        if (inWindow)
        begin
            case (ofs)
                gtc_pkg::OFS_CONFIG:   next_rdData = 32'(cfg[chSel]);
                gtc_pkg::OFS_COUNT_LO: next_rdData = countQ[chSel][31:0];
                gtc_pkg::OFS_COUNT_HI: next_rdData = readLatch[chSel][CW-1:32];
                gtc_pkg::OFS_MIN_LO:   next_rdData = minLim[chSel][31:0];
                gtc_pkg::OFS_MIN_HI:   next_rdData = minLim[chSel][CW-1:32];
                gtc_pkg::OFS_MAX_LO:   next_rdData = maxLim[chSel][31:0];
                gtc_pkg::OFS_MAX_HI:   next_rdData = maxLim[chSel][CW-1:32];
                gtc_pkg::OFS_CMP:      next_rdData = cmpReg[chSel];
                default:               next_rdData = '0;
            endcase
        end
        else if (regAddr == gtc_pkg::ADR_SCAN_MASK)
            next_rdData = 32'(scanMask);
        else if (regAddr == gtc_pkg::ADR_STATUS)
            next_rdData = {24'h000000, halted, compareToggleOutput};
    end

    // scan results are read back only through the per-channel high word; no port returns the snapshot's low word
    always_ff @(posedge core_clk)
    begin
        if (rst)
            regRdData <= '0;
        else if (regRead)
            regRdData <= next_rdData;
        else
            regRdData <= '0;
    end

    // ----------------------------------------
    // indicators
    // ----------------------------------------
    logic [$clog2(ACTIVITY_CYCLES+1)-1:0] blinkCnt;
    always_ff @(posedge core_clk)
    begin
        if (rst || !transferActive)
        begin
            blinkCnt     <= '0;
            activityLamp <= 1'b0;
        end
        else if (blinkCnt == $bits(blinkCnt)'(ACTIVITY_CYCLES - 1))
        begin
            blinkCnt     <= '0;
            activityLamp <= !activityLamp;
        end
        else
            blinkCnt <= blinkCnt + 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            statusLamp <= 1'b0;
        else
            statusLamp <= hostAttached;
    end
endmodule : gtc_counter
`default_nettype wire

// *** hdl/gtc_pkg.sv ***
// gtc_pkg: register map, field positions and mode encodings of the gated totalize counter
package gtc_pkg;
    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int NUM_CHANNELS = 4;
    localparam int COUNT_WIDTH  = 64;
    localparam int ADDR_WIDTH   = 8;
    localparam int DATA_WIDTH   = 32;

    // ----------------------------------------
    // per-channel register window: base = channel * CH_STRIDE
    // ----------------------------------------
    localparam logic [7:0] CH_STRIDE     = 8'h20;
    localparam logic [4:0] OFS_CONFIG    = 5'h00;
    localparam logic [4:0] OFS_COUNT_LO  = 5'h04;
    localparam logic [4:0] OFS_COUNT_HI  = 5'h08;
    localparam logic [4:0] OFS_MIN_LO    = 5'h0c;
    localparam logic [4:0] OFS_MIN_HI    = 5'h10;
    localparam logic [4:0] OFS_MAX_LO    = 5'h14;
    localparam logic [4:0] OFS_MAX_HI    = 5'h18;
    localparam logic [4:0] OFS_CMP       = 5'h1c;
    // ----------------------------------------
    // global registers above the channel windows
    // ----------------------------------------
    localparam logic [7:0] ADR_SCAN_MASK = 8'h80;
    localparam logic [7:0] ADR_SCAN_CMD  = 8'h84;
    localparam logic [7:0] ADR_SCAN_HI   = 8'h88;
    localparam logic [7:0] ADR_STATUS    = 8'h8c;
    localparam logic [7:0] ADR_RELOAD    = 8'h90;

    // ----------------------------------------
    // config register fields
    // ----------------------------------------
    localparam int CFG_MODE_LSB     = 0;   // 2 bits, input mode
    localparam int CFG_CLR_ON_READ  = 2;
    localparam int CFG_RANGE_LIMIT  = 3;
    localparam int CFG_NON_RECYCLE  = 4;
    localparam int CFG_REVERSE      = 5;
    localparam int CFG_OUTPUT_ON    = 6;
    localparam int CFG_OUTPUT_INIT  = 7;
    localparam int CFG_GATE_LSB     = 8;   // 3 bits, gate function
    localparam int CFG_GATE_INVERT  = 11;
    localparam int CFG_ROLL_FREEZE  = 12;  // range limit: 1 freeze, 0 roll over
    localparam int CFG_WIDTH        = 13;
    localparam logic [12:0] CFG_RESET = 13'h0000;

    // compare register: value 0 in low half, value 1 in high half (low 16 bits of count)
    localparam int CMP_HALF = 16;

    typedef enum logic [1:0] {
        MODE_ACCUMULATE,
        MODE_PERIOD,
        MODE_PULSE_WIDTH,
        MODE_TIMING
    } gtc_mode_e;

    typedef enum logic [2:0] {
        GATE_NONE,
        GATE_DIRECTION,
        GATE_ENABLE,
        GATE_CLEAR_RELOAD,
        GATE_TRIGGER
    } gtc_gate_e;

    // activity indicator toggle interval, half the blink period of the activity lamp
    localparam int ACTIVITY_TIME_NS = 50_000_000;
    localparam int CLK_PERIOD_NS    = 20;
    localparam int ACTIVITY_CYCLES  = ACTIVITY_TIME_NS / CLK_PERIOD_NS;
endpackage : gtc_pkg

// *** testbench/gtc_counter_props.sv ***
// gtc_counter_props: port-level checks of the gated totalize counter
`timescale 1ns/1ps
`default_nettype none
module gtc_counter_props #(
    parameter int NUM_CH          = 4,
    parameter int ACTIVITY_CYCLES = 4
) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic [7:0]        regAddr,
    input wire logic [31:0]       regWrData,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [31:0]       regRdData,
    input wire logic [NUM_CH-1:0] pulseInput,
    input wire logic [NUM_CH-1:0] gateInput,
    input wire logic [NUM_CH-1:0] compareToggleOutput,
    input wire logic              hostAttached,
    input wire logic              transferActive,
    input wire logic              statusLamp,
    input wire logic              activityLamp
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_cfg_wr;
        regWrite && regAddr == 8'h00;
    endsequence
    sequence s_cfg_rd;
        regRead && regAddr == 8'h00;
    endsequence
    // inputs quiet long enough for the sync pipeline to drain
    sequence s_quiet;
        (!regWrite && !regRead && pulseInput == '0 && $stable(gateInput))[*8];
    endsequence
    a_rd_idle_zero: assert property (!regRead |=> regRdData == 32'h0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (regRead && regAddr == 8'hfc |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    a_cfg_readback: assert property (s_cfg_wr ##2 s_cfg_rd |=> regRdData[12:0] == $past(regWrData[12:0], 3))
        else $error("config read back differs from write");
    a_status_copy: assert property (1'b1 |=> statusLamp == $past(hostAttached))
        else $error("status lamp does not follow host attach");
    a_act_off: assert property (!transferActive |=> !activityLamp)
        else $error("activity lamp lit while idle");
    a_act_blink: assert property (transferActive[*8] |-> activityLamp != $past(activityLamp, 4))
        else $error("activity lamp not blinking");
    a_reset_quiet: assert property ($fell(rst) |-> compareToggleOutput == '0 && !statusLamp && !activityLamp)
        else $error("outputs not at reset level");
    a_out_quiet: assert property (s_quiet |-> $stable(compareToggleOutput))
        else $error("output moved without a count change");
endmodule : gtc_counter_props
bind gtc_counter gtc_counter_props #(.NUM_CH(NUM_CH), .ACTIVITY_CYCLES(ACTIVITY_CYCLES)) chk_u (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .pulseInput(pulseInput), .gateInput(gateInput),
    .compareToggleOutput(compareToggleOutput), .hostAttached(hostAttached),
    .transferActive(transferActive), .statusLamp(statusLamp), .activityLamp(activityLamp));
`default_nettype wire

// *** testbench/gtc_host_model.sv ***
// gtc_host_model: host side driving the register port and link status
`timescale 1ns/1ps
`default_nettype none
module gtc_host_model (
    input  wire logic        core_clk,
    input  wire logic [31:0] regRdData,
    output logic      [7:0]  regAddr = 8'h00,
    output logic      [31:0] regWrData = 32'h0,
    output logic             regWrite = 1'b0,
    output logic             regRead = 1'b0,
    output logic             hostAttached = 1'b0,
    output logic             transferActive = 1'b0
);
    // a gap cycle after each write keeps strobes one cycle wide
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        v = regRdData;
    endtask : rd
    task automatic link(input logic att, input logic act);
        hostAttached <= att;
        transferActive <= act;
    endtask : link
endmodule : gtc_host_model
`default_nettype wire

// *** testbench/tb.sv ***
// tb: self-checking bench of the gated totalize counter
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  regAddr;
    logic [31:0] regWrData;
    logic        regWrite;
    logic        regRead;
    logic [31:0] regRdData;
    logic [3:0]  pulseInput = 4'h0;
    logic [3:0]  gateInput = 4'h0;
    logic [3:0]  cto;
    logic        hostAttached;
    logic        transferActive;
    logic        statusLamp;
    logic        activityLamp;
    logic [31:0] d;
    logic [31:0] ec [4];
    int          err_total = 0;
    int          n_tests = 0;
    int          cyc = 0;
    always #10 core_clk = ~core_clk;
    gtc_counter #(.ACTIVITY_CYCLES(4)) dut_u (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .pulseInput(pulseInput), .gateInput(gateInput), .compareToggleOutput(cto),
        .hostAttached(hostAttached), .transferActive(transferActive), .statusLamp(statusLamp),
        .activityLamp(activityLamp));
    gtc_host_model host_u (.core_clk(core_clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .hostAttached(hostAttached), .transferActive(transferActive));
    function automatic logic [31:0] clampv(logic [31:0] v, logic [31:0] lo, logic [31:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clampv
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rc(input int ch, input logic [31:0] e);
        host_u.rd(8'(ch * 32 + 4), d);
        chk("count", d, e);
    endtask : rc
    // one edge per two clocks: the fastest rate the sync accepts
    task automatic pulse(input int ch, input int k);
        repeat (k)
        begin
            @(posedge core_clk);
            pulseInput[ch] <= 1'b1;
            @(posedge core_clk);
            pulseInput[ch] <= 1'b0;
        end
        repeat (6) @(posedge core_clk);
        #1;
    endtask : pulse
    task automatic gt(input int ch, input logic v);
        @(posedge core_clk);
        gateInput[ch] <= v;
        repeat (5) @(posedge core_clk);
        #1;
    endtask : gt
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            test_done();
        end
    end
    initial
    begin
        void'($urandom(95334));
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("outputs", 32'({statusLamp, activityLamp, cto}), 32'h0);
        host_u.rd(8'h00, d);
        chk("config", d, 32'h0);
        host_u.rd(8'h34, d);
        chk("max", d, 32'hffffffff);
        host_u.rd(8'hfc, d);
        chk("unmapped", d, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            ec[c] = 32'($urandom_range(12, 1));
            pulse(c, int'(ec[c]));
        end
        for (int c = 0; c < 4; c++)
        begin
            rc(c, ec[c]);
            host_u.rd(8'(c * 32 + 8), d);
            chk("count_hi", d, 32'h0);
        end
        // both limit words are written: the high word of the maximum resets to all ones
        host_u.wr(8'h14, ec[0] + 2);
        host_u.wr(8'h18, 32'h0);
        rc(0, ec[0]);
        host_u.wr(8'h00, 32'h10);
        pulse(0, 5);
        ec[0] = clampv(ec[0] + 5, 0, ec[0] + 2);
        rc(0, ec[0]);
        host_u.wr(8'h00, 32'h30);
        pulse(0, 1);
        ec[0] = ec[0] - 1;
        rc(0, ec[0]);
        host_u.wr(8'h20, 32'h20);
        pulse(1, 1);
        ec[1] = ec[1] - 1;
        rc(1, ec[1]);
        host_u.wr(8'h20, 32'h120);
        gt(1, 1'b1);
        pulse(1, 3);
        rc(1, ec[1] + 3);
        gt(1, 1'b0);
        pulse(1, 1);
        ec[1] = ec[1] + 2;
        rc(1, ec[1]);
        host_u.wr(8'h20, 32'h200);
        pulse(1, 3);
        rc(1, ec[1]);
        gt(1, 1'b1);
        pulse(1, 2);
        rc(1, ec[1] + 2);
        gt(1, 1'b0);
        host_u.wr(8'h20, 32'h300);
        gt(1, 1'b1);
        rc(1, 0);
        gt(1, 1'b0);
        host_u.wr(8'h2c, 32'h7);
        host_u.wr(8'h20, 32'h308);
        gt(1, 1'b1);
        rc(1, 7);
        host_u.wr(8'h40, 32'h400);
        pulse(2, 2);
        rc(2, ec[2]);
        gt(2, 1'b1);
        pulse(2, 2);
        rc(2, ec[2] + 2);
        host_u.wr(8'h4c, 32'h5);
        host_u.wr(8'h54, 32'h8);
        host_u.wr(8'h58, 32'h0);
        host_u.wr(8'h90, 32'h6);
        host_u.wr(8'h94, 32'h0);
        host_u.wr(8'h8c, 32'h4);
        host_u.wr(8'h40, 32'h1008);
        pulse(2, 4);
        rc(2, clampv(10, 5, 8));
        host_u.wr(8'h40, 32'h1028);
        pulse(2, 5);
        rc(2, clampv(3, 5, 8));
        host_u.wr(8'h60, 32'h04);
        pulse(3, 3);
        rc(3, ec[3] + 3);
        rc(3, 0);
        host_u.wr(8'h60, 32'h01);
        pulse(3, 3);
        rc(3, 0);
        host_u.wr(8'h1c, {16'(ec[0] + 3), 16'(ec[0] + 1)});
        host_u.wr(8'h00, 32'h40);
        pulse(0, 1);
        chk("out", 32'(cto[0]), 32'h1);
        pulse(0, 2);
        chk("out", 32'(cto[0]), 32'h0);
        host_u.wr(8'h00, 32'hc0);
        host_u.rd(8'h00, d);
        chk("config", d, 32'hc0);
        chk("out", 32'(cto[0]), 32'h1);
        // a scan snapshot with clear-on-read must clear the member channel
        host_u.wr(8'h00, 32'h04);
        host_u.wr(8'h80, 32'h1);
        host_u.wr(8'h84, 32'h0);
        rc(0, 0);
        host_u.link(1'b1, 1'b1);
        repeat (20) @(posedge core_clk);
        #1;
        chk("status", 32'(statusLamp), 32'h1);
        host_u.link(1'b0, 1'b0);
        repeat (3) @(posedge core_clk);
        #1;
        chk("lamps", 32'({statusLamp, activityLamp}), 32'h0);
        test_done();
    end
endmodule : tb
`default_nettype wire
